// >>> rtl/gpio_pkg.sv
package gpp_pkg;
	localparam int PORT_WIDTH = 8;
	localparam int SYNC_STAGES = 3;
	// Register selects, one location per register
	localparam logic [1:0] SEL_LEVEL = 2'h0;
	localparam logic [1:0] SEL_DIR = 2'h1;
	localparam logic [1:0] SEL_OUT = 2'h2;
	localparam logic [1:0] SEL_NONE = 2'h3;
	// Reset values
	localparam logic RST_BIT = 1'h0;
	localparam logic RST_PUD = 1'h0;

	// One register access from the core
	typedef struct packed {
		logic                  wrEn;
		logic                  rdEn;
		logic [1:0]            sel;
		logic [PORT_WIDTH-1:0] wrData;
		logic [PORT_WIDTH-1:0] bitMask;
	} gpp_access_t;

	// Pad-side drive bundle
	typedef struct packed {
		logic [PORT_WIDTH-1:0] outVal;
		logic [PORT_WIDTH-1:0] outEn;
		logic [PORT_WIDTH-1:0] pullEn;
	} gpp_pad_t;
endpackage

// >>> rtl/gpp_level_sync.sv
`timescale 1ns/1ps
// Per-pin pad synchroniser: negative-edge stage stands in for the
// transparent-high latch, then a rising-edge register.
module gpp_level_sync
	import gpp_pkg::*;
#(
	parameter int WIDTH = PORT_WIDTH
) (
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] padIn,
	output logic      [WIDTH-1:0] level
);
	logic [WIDTH-1:0] latchStage;
	logic [WIDTH-1:0] next_latchStage;
	logic [WIDTH-1:0] next_level;

	// Latch holds while clock is low, so capture at the falling edge
	always_comb begin
		next_latchStage = padIn;
		next_level = latchStage;
	end

	// Half-cycle sampling gives the half to one-and-a-half period delay
	always_ff @(negedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			latchStage <= '0;
		end else begin
			latchStage <= next_latchStage;
		end
	end

	// Second stage feeds the level register only
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			level <= '0;
		end else begin
			level <= next_level;
		end
	end
endmodule

// >>> rtl/gpp_port.sv
`timescale 1ns/1ps
module gpp_port
	import gpp_pkg::*;
#(
	parameter int WIDTH = PORT_WIDTH
) (
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	input  wire gpp_access_t      access,
	input  wire logic             pudWrEn,
	input  wire logic             pudWrData,
	input  wire logic [WIDTH-1:0] altEnable,
	input  wire logic [WIDTH-1:0] padIn,
	output logic      [WIDTH-1:0] rdData,
	output logic                  globalPullupDisable,
	output logic      [WIDTH-1:0] padOut,
	output logic      [WIDTH-1:0] padOutEn,
	output logic      [WIDTH-1:0] padPullEn
);
	if (WIDTH < 1 || WIDTH > PORT_WIDTH) begin : g_width_check
		$error("gpp_port WIDTH out of range");
	end

	logic [WIDTH-1:0] portOut;
	logic [WIDTH-1:0] portDir;
	logic [WIDTH-1:0] level;
	logic [WIDTH-1:0] next_portOut;
	logic [WIDTH-1:0] next_portDir;
	logic             next_pud;
	logic [WIDTH-1:0] next_rdData;
	logic [WIDTH-1:0] next_padOut;
	logic [WIDTH-1:0] next_padOutEn;
	logic [WIDTH-1:0] next_padPullEn;
	logic [WIDTH-1:0] mask;
	logic [WIDTH-1:0] wdat;
	logic [WIDTH-1:0] pullPerPin;

	// Pin modes by {direction, output data}:
	//   00 input, floating
	//   01 input, pulled up unless the global disable or the pin's altEnable bit is set
	//   10 output, driving low
	//   11 output, driving high
	// Toggling through the level location flips only the output data,
	// so an input pin moves between floating and pulled up.

	// Software obligations this block does not police:
	// - tri-state to driven high must pass through pull-up or driven
	//   low first; set the pull-up disable if the pull-up is unwanted
	// - pull-up to driven low, and back, must pass through tri-state
	//   or driven high
	// - reading the level right after an output write needs one idle
	//   access, since the pad level arrives one period later
	// Direct jumps still work here; the hazard is on the board, where
	// a brief wrong level could glitch whatever the pin drives.

	// Merge a masked write so untouched pins keep their setting
	function automatic logic [WIDTH-1:0] merge(
		input logic [WIDTH-1:0] old,
		input logic [WIDTH-1:0] val,
		input logic [WIDTH-1:0] msk
	);
		merge = (old & ~msk) | (val & msk);
	endfunction

	// Pull-up decode for one pin from {direction, output, disable} and its altEnable bit.
	// Only an input holding one with the disable clear pulls, so a
	// strong driver and the resistor never work against each other.
	function automatic logic pullDecode(
		input logic dirBit,
		input logic outBit,
		input logic global_pullup_disable,
		input logic alt
	);
		unique case ({dirBit, outBit, global_pullup_disable})
			3'h2:    pullDecode = ~alt;
			default: pullDecode = 1'h0;
		endcase
	endfunction

	// One decoder per pin; an alternate pin drops only its own
	// pull-up, so the rest of the port stays general I/O
	for (genvar p = 0; p < WIDTH; p++) begin : g_pin_pull
		assign pullPerPin[p] = pullDecode(next_portDir[p],
			next_portOut[p], next_pud, altEnable[p]);
	end

	assign mask = access.bitMask[WIDTH-1:0];
	assign wdat = access.wrData[WIDTH-1:0];

	gpp_level_sync #(
		.WIDTH(WIDTH)
	) u_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.padIn  (padIn),
		.level  (level)
	);

	// Register writes; a mask of one bit acts as a set or clear at the output and direction locations, and as a toggle at the level location
	always_comb begin
		next_portOut = portOut;
		next_portDir = portDir;
		next_pud = globalPullupDisable;
		if (access.wrEn) begin
			unique case (access.sel)
				SEL_OUT: next_portOut = merge(portOut, wdat, mask);
				SEL_DIR: next_portDir = merge(portDir, wdat, mask);
				SEL_LEVEL: next_portOut = portOut ^ (wdat & mask);
				SEL_NONE: next_portOut = portOut;
			endcase
		end
		if (pudWrEn) begin
			next_pud = pudWrData;
		end
	end

	// Read path; a read in the cycle of a write returns the old value
	always_comb begin
		next_rdData = '0;
		if (access.rdEn) begin
			unique case (access.sel)
				SEL_OUT: next_rdData = portOut;
				SEL_DIR: next_rdData = portDir;
				SEL_LEVEL: next_rdData = level;
				SEL_NONE: next_rdData = '0;
			endcase
		end
	end

	// Pad drive follows the new value so level sees it a period on
	always_comb begin
		next_padOut = next_portOut;
		next_padOutEn = next_portDir;
		next_padPullEn = pullPerPin;
	end

	// Configuration state; reset leaves every pin an input, no pull
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			portOut <= {WIDTH{RST_BIT}};
			portDir <= {WIDTH{RST_BIT}};
			globalPullupDisable <= RST_PUD;
		end else begin
			portOut <= next_portOut;
			portDir <= next_portDir;
			globalPullupDisable <= next_pud;
		end
	end

	// Async reset tri-states pads with no clock needed, since a pad
	// left driving during reset could fight whatever the board holds
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdData <= '0;
			padOut <= '0;
			padOutEn <= '0;
			padPullEn <= '0;
		end else begin
			rdData <= next_rdData;
			padOut <= next_padOut;
			padOutEn <= next_padOutEn;
			padPullEn <= next_padPullEn;
		end
	end
endmodule

// >>> verification/gpp_pad_model.sv
`timescale 1ns/1ps
// Pads: driven pins echo, pulled pins rise, others wander
module gpp_pad_model
	import gpp_pkg::*;
(
	input  wire logic [PORT_WIDTH-1:0] drive,
	input  wire logic [PORT_WIDTH-1:0] en,
	input  wire logic [PORT_WIDTH-1:0] pull,
	input  wire logic [PORT_WIDTH-1:0] ext,
	output logic      [PORT_WIDTH-1:0] level
);
	assign level = (en & drive) | (~en & (pull | ext));
endmodule

// >>> verification/gpp_port_monitor.sv
`timescale 1ns/1ps
module gpp_port_monitor
	import gpp_pkg::*;
#(parameter int WIDTH = PORT_WIDTH) (
	input wire logic             ref_clk,
	input wire logic             reset_n,
	input wire gpp_access_t      access,
	input wire logic             pudWrEn,
	input wire logic             pudWrData,
	input wire logic [WIDTH-1:0] altEnable,
	input wire logic [WIDTH-1:0] padIn,
	input wire logic [WIDTH-1:0] rdData,
	input wire logic             globalPullupDisable,
	input wire logic [WIDTH-1:0] padOut,
	input wire logic [WIDTH-1:0] padOutEn,
	input wire logic [WIDTH-1:0] padPullEn
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	sequence wrAt(logic [1:0] s);
		access.wrEn && access.sel == s;
	endsequence
	chk_pull_rule: assert property (padPullEn == (~padOutEn & padOut
		& ~{WIDTH{globalPullupDisable}} & ~$past(altEnable))) else $error("pull");
	chk_out_write: assert property (wrAt(SEL_OUT) |=>
		((padOut ^ $past(access.wrData)) & $past(access.bitMask)) == 0)
		else $error("out");
	chk_dir_write: assert property (wrAt(SEL_DIR) |=>
		((padOutEn ^ $past(access.wrData)) & $past(access.bitMask)) == 0)
		else $error("dir");
	chk_level_toggle: assert property (wrAt(SEL_LEVEL) |=> padOut ==
		($past(padOut) ^ ($past(access.wrData) & $past(access.bitMask))))
		else $error("toggle");
	chk_none_write: assert property (wrAt(SEL_NONE) |=>
		$stable(padOut) && $stable(padOutEn)) else $error("none");
	chk_pud_write: assert property (pudWrEn |=>
		globalPullupDisable == $past(pudWrData)) else $error("pud");
	chk_dir_read: assert property (access.rdEn && access.sel == SEL_DIR
		|=> rdData == $past(padOutEn)) else $error("rd");
	chk_idle_read: assert property (!access.rdEn |=> rdData == 0)
		else $error("idle");
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import gpp_pkg::*;
	logic        ref_clk = 0, reset_n = 0, pudWrEn = 0, pudWrData = 0;
	logic        took = 0, globalPullupDisable;
	gpp_access_t access = '0;
	logic [7:0]  altEnable = 0, ext = 0, padIn, rdData, padOut, padOutEn;
	logic [7:0]  padPullEn, d, e, expQ[$];
	int          n_errors = 0, checked = 0, seed = 32'ha027acc6;
	always #2 ref_clk = ~ref_clk;
	gpp_port gpp_port_i(.ref_clk, .reset_n, .access, .pudWrEn, .pudWrData,
		.altEnable, .padIn, .rdData, .globalPullupDisable, .padOut,
		.padOutEn, .padPullEn);
	gpp_pad_model gpp_pad_model_i(.drive(padOut), .en(padOutEn),
		.pull(padPullEn), .ext, .level(padIn));
	task check(string nm, logic [7:0] s, x);
		checked++;
		if (s !== x) begin n_errors++; $display("unexpected %s %h %h", nm, x, s); end
	endtask
	task final_report;
		if (n_errors == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task acc(logic w, r, logic [1:0] s, logic [7:0] dt, m);
		@(negedge ref_clk) access <= '{w, r, s, dt, m};
	endtask
	task rd(logic [1:0] s, logic [7:0] x);
		acc(0, 1, s, 0, 0);
		expQ.push_back(x);
		acc(0, 0, SEL_NONE, 0, 0);
	endtask
	// Unpulled floating pads change every cycle
	always @(negedge ref_clk) ext <= $random(seed);
	// Watcher pairs each read result with the oldest note
	always @(posedge ref_clk) took <= access.rdEn;
	always @(negedge ref_clk) if (took) check("rd", rdData, expQ.pop_front());
	initial begin
		repeat (3) @(negedge ref_clk);
		reset_n = 1;
		rd(SEL_OUT, 0);
		rd(SEL_DIR, 0);
		d = $random(seed);
		e = $random(seed);
		altEnable = $random(seed);
		acc(1, 0, SEL_OUT, d, 8'hff);
		acc(1, 0, SEL_DIR, e, 8'hff);
		acc(1, 0, SEL_DIR, ~e, 8'h0f);
		acc(1, 0, SEL_NONE, ~d, 8'hff);
		acc(1, 0, SEL_LEVEL, 8'h81, 8'hff);
		rd(SEL_OUT, d ^ 8'h81);
		rd(SEL_DIR, {e[7:4], ~e[3:0]});
		acc(1, 0, SEL_DIR, 8'hff, 8'hff);
		acc(0, 0, SEL_NONE, 0, 0);
		acc(0, 0, SEL_NONE, 0, 0);
		rd(SEL_LEVEL, d ^ 8'h81);
		acc(1, 0, SEL_OUT, 8'hff, 8'hff);
		acc(1, 0, SEL_DIR, 0, 8'hff);
		acc(0, 0, SEL_NONE, 0, 0);
		@(negedge ref_clk) check("pull", padPullEn, ~altEnable);
		pudWrEn = 1;
		pudWrData = 1;
		@(negedge ref_clk) pudWrEn = 0;
		@(negedge ref_clk) check("pud", padPullEn, 0);
		pudWrEn = 1;
		pudWrData = 0;
		acc(1, 0, SEL_OUT, 0, 8'h01);
		pudWrEn = 0;
		@(negedge ref_clk) check("drop", padPullEn, ~altEnable & 8'hfe);
		#1 reset_n = 0;
		#0.5 check("rst", padOutEn | padPullEn, 0);
		final_report;
	end
	// Hang guard
	initial begin #20000 n_errors++; final_report; end
endmodule
bind gpp_port gpp_port_monitor #(.WIDTH(WIDTH)) gpp_port_monitor_i(.*);
